// ---- core/dcc_core_ctrl.sv ----
// core control register, ram modulo split and control port byte framing
`timescale 1ns/10ps
`include "dcc_cfg.svh"

module dcc_core_ctrl #(
  parameter logic [6:0] CHIP_ADDR = 7'h2A // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control port byte link
  input wire logic cp_byte_valid,
  input wire logic [7:0] cp_byte,
  input wire logic control_latch,
  output logic [7:0] cp_rd_byte,
  // program and parameter ram writes
  output logic ram_wr_valid,
  output dcc_pkg::dcc_ram_wr_t ram_wr,
  // safeload writes
  output logic sl_wr_valid,
  output dcc_pkg::dcc_sl_wr_t sl_wr,
  // frame clock pins
  input wire logic in_frame_clk,
  input wire logic out_frame_clk,
  // sequencer
  output logic [10:0] pc,
  output logic prog_end,
  output logic out_latch,
  output logic acc_clear,
  // data path gating
  input wire logic [27:0] mult_in,
  output logic [27:0] mult_in_gated,
  input wire logic [23:0] in_sample,
  output logic [23:0] in_sample_q,
  // data memory access
  input wire logic [12:0] core_dm_addr,
  input wire logic core_dm_we,
  input wire logic [27:0] core_dm_wdata,
  output logic [12:0] dm_addr,
  output logic dm_we,
  output logic [27:0] dm_wdata
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // data bytes per word for an address
  function automatic logic [2:0] word_bytes(input logic [11:0] a);
    if (a < `DCC_ADR_PROG_BASE) return 3'd4;
    else if (a < `DCC_ADR_SLD_ADDR) return 3'd5;
    else if (a < `DCC_ADR_SLD_END) return 3'd2;
    else if (a == `DCC_ADR_RAMCFG) return 3'd1;
    else return 3'd2;
  endfunction

  // modulo translation of a data memory address
  function automatic logic [12:0] phys(input logic [12:0] a, input logic [12:0] off,
                                       input logic [12:0] bnd);
    logic [13:0] sum;
    sum = {1'b0, a} + {1'b0, off};
    if (a >= bnd) return a;
    else if (sum >= {1'b0, bnd}) return 13'(sum - {1'b0, bnd});
    else return sum[12:0];
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] core;
  logic [15:0] next_core;
  logic [3:0] ramcfg;
  logic [33:0] sl_data [`DCC_SL_PAIRS];
  logic [9:0] sl_addr [`DCC_SL_PAIRS];
  logic [`DCC_SL_PAIRS-1:0] sl_dirty;
  logic [`DCC_SL_PAIRS-1:0] next_dirty;
  logic latch_s1, latch_s2;
  logic [2:0] in_fr;
  logic [2:0] out_fr;
  dcc_pkg::dcc_cp_state_t state;
  logic rw;
  logic [11:0] addr;
  logic [39:0] shreg;
  logic [2:0] cnt;
  logic [39:0] word;
  logic word_done;
  logic [15:0] rd_val;
  logic [2:0] need;
  logic [2:0] sync_cnt;
  logic align;
  logic running;
  logic [10:0] len_m1;
  logic end_now;
  logic [12:0] bnd;
  logic [3:0] eff;
  logic [12:0] offset;
  logic mz_busy;
  logic [12:0] mz_addr;
  logic clr_mz;
  logic sl_busy;
  logic sl_tgt;
  logic [2:0] sl_idx;
  logic clr_par, clr_tgt;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // third stage only feeds the edge detectors
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latch_s1 <= 1'b1;
      latch_s2 <= 1'b1;
      in_fr <= 3'h0;
      out_fr <= 3'h0;
    end
    else
    begin
      latch_s1 <= control_latch;
      latch_s2 <= latch_s1;
      in_fr <= {in_fr[1:0], in_frame_clk};
      out_fr <= {out_fr[1:0], out_frame_clk};
    end
  end

  // ----------------------------------------------------------------
  // control port framing
  // ----------------------------------------------------------------
  assign need = word_bytes(addr);
  assign word = {shreg[31:0], cp_byte};
  assign word_done = (state == dcc_pkg::ST_DATA) && cp_byte_valid && (cnt == need - 3'd1);

  // readback of the local registers, pending bits stay visible
  always_comb
  begin
    rd_val = 16'h0000;
    if (addr == `DCC_ADR_CORE) rd_val = core;
    else if (addr == `DCC_ADR_RAMCFG) rd_val = {12'h000, ramcfg};
  end

  // header, then words; latch high aborts or ends the transaction
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= dcc_pkg::ST_HDR0;
      rw <= 1'b0;
      addr <= 12'h000;
      shreg <= 40'h0;
      cnt <= 3'h0;
    end
    else if (latch_s2)
    begin
      state <= dcc_pkg::ST_HDR0;
      cnt <= 3'h0;
    end
    else if (cp_byte_valid)
    begin
      case (state)
        dcc_pkg::ST_HDR0:
        begin
          rw <= cp_byte[0];
          state <= (cp_byte[7:1] == CHIP_ADDR) ? dcc_pkg::ST_HDR1 : dcc_pkg::ST_SKIP;
        end
        dcc_pkg::ST_HDR1:
        begin
          addr[11:8] <= cp_byte[3:0];
          state <= dcc_pkg::ST_HDR2;
        end
        dcc_pkg::ST_HDR2:
        begin
          addr[7:0] <= cp_byte;
          cnt <= 3'h0;
          shreg <= 40'h0;
          state <= dcc_pkg::ST_DATA;
        end
        dcc_pkg::ST_DATA:
        begin
          shreg <= word; // most significant byte first
          cnt <= cnt + 3'd1;
          if (word_done)
          begin
            cnt <= 3'h0;
            shreg <= 40'h0;
            if (addr == `DCC_ADR_LAST) state <= dcc_pkg::ST_SKIP;
            else addr <= addr + 12'd1;
          end
        end
        dcc_pkg::ST_SKIP: state <= dcc_pkg::ST_SKIP;
        default: state <= dcc_pkg::ST_HDR0;
      endcase
    end
  end

  // readback byte answers each data slot of a read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) cp_rd_byte <= 8'h00;
    else if (cp_byte_valid && state == dcc_pkg::ST_DATA && rw)
      cp_rd_byte <= 8'((40'(rd_val)) >> {(need - 3'd1 - cnt), 3'b000});
  end

  // ram words leave as one registered pulse; leading pad bits dropped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_wr_valid <= 1'b0;
      ram_wr <= '0;
    end
    else
    begin
      ram_wr_valid <= word_done && !rw && addr < `DCC_ADR_SLD_DATA;
      if (word_done)
      begin
        ram_wr.addr <= addr;
        ram_wr.data <= (addr < `DCC_ADR_PROG_BASE) ? {12'h000, word[27:0]} : word;
      end
    end
  end

  // ----------------------------------------------------------------
  // core control and ram configuration registers
  // ----------------------------------------------------------------
  // hardware clears first, so a same-cycle write of one wins
  always_comb
  begin
    next_core = core;
    if (clr_mz) next_core[`DCC_BIT_MZERO] = 1'b0;
    if (clr_tgt) next_core[`DCC_BIT_SLTGT] = 1'b0;
    if (clr_par) next_core[`DCC_BIT_SLPAR] = 1'b0;
    if (word_done && !rw && addr == `DCC_ADR_CORE)
      next_core = (word[15:0] & `DCC_CORE_WMASK) | (next_core & `DCC_CORE_SELF);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core <= `DCC_CORE_RESET;
      ramcfg <= 4'h0;
    end
    else
    begin
      core <= next_core;
      if (word_done && !rw && addr == `DCC_ADR_RAMCFG) ramcfg <= word[3:0];
    end
  end

  // ----------------------------------------------------------------
  // safeload pairs
  // ----------------------------------------------------------------
  // a write marks its pair; sending clears it unless rewritten now
  always_comb
  begin
    next_dirty = sl_dirty;
    if (sl_busy) next_dirty[sl_idx] = 1'b0;
    for (int i = 0; i < `DCC_SL_PAIRS; i++)
    begin
      if (word_done && !rw && (addr == `DCC_ADR_SLD_DATA + 12'(i)
          || addr == `DCC_ADR_SLD_ADDR + 12'(i)))
        next_dirty[i] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sl_dirty <= '0;
      for (int i = 0; i < `DCC_SL_PAIRS; i++)
      begin
        sl_data[i] <= 34'h0;
        sl_addr[i] <= 10'h000;
      end
    end
    else
    begin
      sl_dirty <= next_dirty;
      for (int i = 0; i < `DCC_SL_PAIRS; i++)
      begin
        if (word_done && !rw && addr == `DCC_ADR_SLD_DATA + 12'(i)) sl_data[i] <= word[33:0];
        if (word_done && !rw && addr == `DCC_ADR_SLD_ADDR + 12'(i)) sl_addr[i] <= word[9:0];
      end
    end
  end

  // transfer starts at program end, while the core leaves ram alone
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sl_busy <= 1'b0;
      sl_tgt <= 1'b0;
      sl_idx <= 3'h0;
      sl_wr_valid <= 1'b0;
      sl_wr <= '0;
    end
    else
    begin
      sl_wr_valid <= sl_busy && sl_dirty[sl_idx];
      sl_wr.target <= sl_tgt;
      sl_wr.addr <= sl_addr[sl_idx]; // offset zero is first location
      sl_wr.data <= sl_data[sl_idx];
      if (!sl_busy && end_now && (core[`DCC_BIT_SLPAR] || core[`DCC_BIT_SLTGT]))
      begin
        sl_busy <= 1'b1;
        sl_idx <= 3'h0;
        sl_tgt <= !core[`DCC_BIT_SLPAR]; // parameter request served first
      end
      else if (sl_busy)
      begin
        // index parks on the last pair so the pair arrays are never read out of range
        if (sl_idx == `DCC_SL_LAST) sl_busy <= 1'b0;
        else sl_idx <= sl_idx + 3'd1;
      end
    end
  end

  assign clr_par = sl_busy && sl_idx == `DCC_SL_LAST && !sl_tgt;
  assign clr_tgt = sl_busy && sl_idx == `DCC_SL_LAST && sl_tgt;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // align on every 1st, 2nd, 4th or 8th input frame edge
  assign align = in_fr[1] && !in_fr[2]
    && ((sync_cnt & ((3'h1 << core[`DCC_SYNC_HI:`DCC_SYNC_LO]) - 3'h1)) == 3'h0);
  assign len_m1 = (`DCC_STEPS_FULL >> core[`DCC_LEN_HI:`DCC_LEN_LO]) - 11'd1;
  assign end_now = running && pc == len_m1;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_cnt <= 3'h0;
      pc <= 11'h000;
      running <= 1'b0;
      prog_end <= 1'b0;
    end
    else
    begin
      if (in_fr[1] && !in_fr[2]) sync_cnt <= sync_cnt + 3'd1;
      prog_end <= end_now;
      if (align)
      begin
        pc <= 11'h000;
        running <= 1'b1;
      end
      else if (end_now) running <= 1'b0; // waits here for the next alignment
      else if (running) pc <= pc + 11'd1;
    end
  end

  // output transfer strobe and clear level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_latch <= 1'b0;
      acc_clear <= 1'b1;
    end
    else
    begin
      acc_clear <= !core[`DCC_BIT_CLRN];
      if (!core[`DCC_BIT_CLRN]) out_latch <= 1'b0;
      else if (core[`DCC_BIT_OLATCH]) out_latch <= out_fr[1] && !out_fr[2];
      else out_latch <= end_now;
    end
  end

  // ----------------------------------------------------------------
  // data path gating
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mult_in_gated <= 28'h0;
      in_sample_q <= 24'h0;
    end
    else
    begin
      mult_in_gated <= core[`DCC_BIT_FMUL] ? 28'h0 : mult_in;
      in_sample_q <= core[`DCC_BIT_IMUTE] ? 24'h0 : in_sample; // every channel slot
    end
  end

  // ----------------------------------------------------------------
  // data memory addressing and zero fill
  // ----------------------------------------------------------------
  // zero and out-of-range settings cover the whole memory
  assign eff = (ramcfg == 4'h0 || ramcfg > `DCC_MOD_MAX) ? `DCC_MOD_MAX : ramcfg;
  assign bnd = 13'({eff, 9'h000});

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) offset <= 13'h0000;
    else if (offset >= bnd) offset <= 13'h0000;
    else if (align) offset <= (offset + 13'd1 >= bnd) ? 13'h0000 : offset + 13'd1;
  end

  // zero fill owns the memory port; core accesses are dropped meanwhile
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mz_busy <= 1'b0;
      mz_addr <= 13'h0000;
    end
    else if (!mz_busy && core[`DCC_BIT_MZERO] && !clr_mz)
    begin
      mz_busy <= 1'b1;
      mz_addr <= 13'h0000;
    end
    else if (mz_busy)
    begin
      mz_addr <= mz_addr + 13'd1;
      if (mz_addr == `DCC_DM_LAST) mz_busy <= 1'b0;
    end
  end

  assign clr_mz = mz_busy && mz_addr == `DCC_DM_LAST;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dm_addr <= 13'h0000;
      dm_we <= 1'b0;
      dm_wdata <= 28'h0;
    end
    else
    begin
      dm_addr <= mz_busy ? mz_addr : phys(core_dm_addr, offset, bnd);
      dm_we <= mz_busy || core_dm_we;
      dm_wdata <= mz_busy ? 28'h0 : core_dm_wdata;
    end
  end

endmodule

// ---- core/dcc_cfg.svh ----
// constants for the dsp core control and control port framing block
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// control port address map (12-bit addresses)
`define DCC_ADR_PROG_BASE 12'h400
`define DCC_ADR_SLD_DATA 12'hA00
`define DCC_ADR_SLD_ADDR 12'hA05
`define DCC_ADR_SLD_END 12'hA0A
`define DCC_ADR_CORE 12'hA52
`define DCC_ADR_RAMCFG 12'hA53
`define DCC_ADR_LAST 12'hA53
// core control register layout
`define DCC_CORE_RESET 16'h0000
`define DCC_CORE_WMASK 16'h17FF
`define DCC_CORE_SELF 16'h00B0
`define DCC_BIT_OLATCH 10
`define DCC_BIT_CLRN 9
`define DCC_BIT_FMUL 8
`define DCC_BIT_MZERO 7
`define DCC_BIT_IMUTE 6
`define DCC_BIT_SLTGT 5
`define DCC_BIT_SLPAR 4
`define DCC_SYNC_HI 3
`define DCC_SYNC_LO 2
`define DCC_LEN_HI 1
`define DCC_LEN_LO 0
// ram configuration register
`define DCC_RAMCFG_RESET 8'h00
`define DCC_MOD_MAX 4'hC
`define DCC_MOD_SHIFT 9
`define DCC_DM_LAST 13'h17FF
// sequencer and safeload
`define DCC_STEPS_FULL 11'h600
`define DCC_SL_PAIRS 5
`define DCC_SL_LAST 3'h4
`endif

// ---- core/dcc_pkg.sv ----
// types shared by the dsp core control block
package dcc_pkg;
  typedef enum logic [2:0] {ST_HDR0, ST_HDR1, ST_HDR2, ST_DATA, ST_SKIP} dcc_cp_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [39:0] data;
  } dcc_ram_wr_t;
  typedef struct packed {
    logic target;
    logic [9:0] addr;
    logic [33:0] data;
  } dcc_sl_wr_t;
endpackage

// ---- test/dcc_core_ctrl_properties.sv ----
// concurrent checks on the core control block ports
`timescale 1ns/10ps
module dcc_core_ctrl_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ram writes
  input wire logic ram_wr_valid,
  input wire dcc_pkg::dcc_ram_wr_t ram_wr,
  // sequencer
  input wire logic [10:0] pc,
  input wire logic prog_end,
  input wire logic out_latch,
  input wire logic acc_clear,
  // data path gating
  input wire logic [27:0] mult_in,
  input wire logic [27:0] mult_in_gated,
  input wire logic [23:0] in_sample,
  input wire logic [23:0] in_sample_q,
  // data memory
  input wire logic core_dm_we,
  input wire logic [27:0] core_dm_wdata,
  input wire logic dm_we,
  input wire logic [27:0] dm_wdata
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // shortest word is four strobes, so ram writes never come closer
  sequence quiet_word;
    !ram_wr_valid [*3];
  endsequence
  rst_clear_a: assert property ($rose(nrst) |-> acc_clear && !out_latch)
    else $error("not cleared after reset");
  latch_gate_a: assert property (out_latch |-> !acc_clear)
    else $error("output transfer while cleared");
  mult_gate_a: assert property (mult_in_gated != 28'h0 |-> mult_in_gated == $past(mult_in))
    else $error("multiplier input wrong");
  in_mute_a: assert property (in_sample_q != 24'h0 |-> in_sample_q == $past(in_sample))
    else $error("serial input wrong");
  dm_pass_a: assert property (dm_we && dm_wdata != 28'h0 |->
    $past(core_dm_we) && dm_wdata == $past(core_dm_wdata))
    else $error("memory write data wrong");
  param_pad_a: assert property (ram_wr_valid && ram_wr.addr < 12'h400 |->
    ram_wr.data[39:28] == 12'h0)
    else $error("parameter word not padded");
  ram_range_a: assert property (ram_wr_valid |-> ram_wr.addr < 12'hA00)
    else $error("ram write outside ram");
  wr_spacing_a: assert property (ram_wr_valid |=> quiet_word)
    else $error("ram writes too close");
  pc_step_a: assert property (pc != $past(pc) |-> pc == $past(pc) + 11'h1 || pc == 11'h0)
    else $error("program counter jump");
  pc_len_a: assert property (pc <= 11'h5FF)
    else $error("program counter too large");
  end_hold_a: assert property (prog_end |-> $stable(pc))
    else $error("counter moved at program end");
endmodule
bind dcc_core_ctrl dcc_core_ctrl_properties i_props (.clk(clk), .nrst(nrst),
  .ram_wr_valid(ram_wr_valid), .ram_wr(ram_wr), .pc(pc), .prog_end(prog_end),
  .out_latch(out_latch), .acc_clear(acc_clear), .mult_in(mult_in),
  .mult_in_gated(mult_in_gated), .in_sample(in_sample), .in_sample_q(in_sample_q),
  .core_dm_we(core_dm_we), .core_dm_wdata(core_dm_wdata), .dm_we(dm_we), .dm_wdata(dm_wdata));

// ---- test/dcc_host_model.sv ----
// host controller model framing control port bytes
`timescale 1ns/10ps
module dcc_host_model (
  // clock
  input wire logic clk,
  // control port
  output logic cp_byte_valid,
  output logic [7:0] cp_byte,
  output logic control_latch
);
  // idle: latch high, bus shows the inverse of the last byte
  initial
  begin
    cp_byte_valid = 1'b0;
    cp_byte = 8'hFF;
    control_latch = 1'b1;
  end
  // one strobe, held across one rising edge
  task put(input logic [7:0] b);
    @(negedge clk);
    cp_byte_valid = 1'b1;
    cp_byte = b;
    @(negedge clk);
    cp_byte_valid = 1'b0;
    cp_byte = ~b;
  endtask
  // latch low early so the two-stage sync sees it before byte 0
  task open(input logic [6:0] chip, input logic rd, input logic [11:0] adr);
    @(negedge clk);
    control_latch = 1'b0;
    repeat (3) @(negedge clk);
    put({chip, rd});
    put({4'h0, adr[11:8]});
    put(adr[7:0]);
  endtask
  // zero-padded word, most significant byte first
  task word(input logic [39:0] d, input int n);
    for (int i = n - 1; i >= 0; i--)
      put(d[8*i +: 8]);
  endtask
  // latch high ends a single write or a burst
  task close();
    @(negedge clk);
    control_latch = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ---- test/tb_dcc_core_ctrl.sv ----
// self-checking bench for the core control block
`timescale 1ns/10ps
module tb_dcc_core_ctrl;
  localparam logic [6:0] CHIP = 7'h2A; // arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic in_frame_clk = 1'b0;
  logic out_frame_clk = 1'b0;
  logic cp_byte_valid, control_latch, ram_wr_valid, sl_wr_valid, prog_end, out_latch;
  logic acc_clear, dm_we, core_dm_we;
  logic [7:0] cp_byte, cp_rd_byte;
  dcc_pkg::dcc_ram_wr_t ram_wr, last_ram;
  dcc_pkg::dcc_sl_wr_t sl_wr, last_sl;
  logic [10:0] pc;
  logic [27:0] mult_in, mult_in_gated, core_dm_wdata, dm_wdata;
  logic [23:0] in_sample, in_sample_q;
  logic [12:0] core_dm_addr, dm_addr, dm_seen;
  logic [15:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  int n_ram = 0;
  int n_sl = 0;
  int n_zero = 0;
  int n_end = 0;
  int n_lat = 0;
  // ----------------------------------------
  // clocks, instances, monitors
  // ----------------------------------------
  always #5 clk = ~clk;
  // frame edges land on falling clk edges; output frames twice the input rate
  always #2000 in_frame_clk = ~in_frame_clk;
  always #1000 out_frame_clk = ~out_frame_clk;
  dcc_host_model i_dcc_host_model (.clk(clk), .cp_byte_valid(cp_byte_valid),
    .cp_byte(cp_byte), .control_latch(control_latch));
  dcc_core_ctrl #(.CHIP_ADDR(CHIP)) i_dcc_core_ctrl (.clk(clk), .nrst(nrst),
    .cp_byte_valid(cp_byte_valid), .cp_byte(cp_byte), .control_latch(control_latch),
    .cp_rd_byte(cp_rd_byte), .ram_wr_valid(ram_wr_valid), .ram_wr(ram_wr),
    .sl_wr_valid(sl_wr_valid), .sl_wr(sl_wr), .in_frame_clk(in_frame_clk),
    .out_frame_clk(out_frame_clk), .pc(pc), .prog_end(prog_end), .out_latch(out_latch),
    .acc_clear(acc_clear), .mult_in(mult_in), .mult_in_gated(mult_in_gated),
    .in_sample(in_sample), .in_sample_q(in_sample_q), .core_dm_addr(core_dm_addr),
    .core_dm_we(core_dm_we), .core_dm_wdata(core_dm_wdata), .dm_addr(dm_addr),
    .dm_we(dm_we), .dm_wdata(dm_wdata));
  // pulse counters; tasks zero them at falling edges, so no race
  always @(posedge clk)
  begin
    n_ram += (ram_wr_valid === 1'b1);
    n_sl += (sl_wr_valid === 1'b1);
    n_zero += (dm_we === 1'b1 && dm_wdata === 28'h0);
    n_end += (prog_end === 1'b1);
    n_lat += (out_latch === 1'b1);
    if (ram_wr_valid === 1'b1)
      last_ram = ram_wr;
    if (sl_wr_valid === 1'b1)
      last_sl = sl_wr;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [39:0] d, input int n);
    i_dcc_host_model.open(CHIP, 1'b0, a);
    i_dcc_host_model.word(d, n);
    i_dcc_host_model.close();
  endtask
  // a read needs one dummy strobe per data byte
  task rd_reg(input logic [11:0] a, input int n);
    rd = 16'h0;
    i_dcc_host_model.open(CHIP, 1'b1, a);
    repeat (n)
    begin
      i_dcc_host_model.put(8'h00);
      @(negedge clk);
      rd = {rd[7:0], cp_rd_byte};
    end
    i_dcc_host_model.close();
  endtask
  // park well after the program end of the current frame
  task align();
    @(posedge in_frame_clk);
    repeat (250) @(negedge clk);
  endtask
  task stop_test();
    $display("tests=%0d bad=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    chk(acc_clear, 1'b1);
    rd_reg(12'hA52, 2);
    chk(rd, 16'h0000);
  endtask
  task t_gate();
    mult_in = 28'h0ABCDEF;
    in_sample = 24'h123456;
    wr(12'hA52, 40'h0100, 2);
    chk(mult_in_gated, 28'h0);
    chk(in_sample_q, 24'h123456);
    wr(12'hA52, 40'h0240, 2);
    chk(acc_clear, 1'b0);
    chk(mult_in_gated, 28'h0ABCDEF);
    chk(in_sample_q, 24'h0);
  endtask
  // burst from the last parameter into the first program word, then refusals
  task t_burst();
    n_ram = 0;
    i_dcc_host_model.open(CHIP, 1'b0, 12'h3FF);
    i_dcc_host_model.word(40'h000ABCDEF1, 4);
    repeat (2) @(negedge clk);
    chk(last_ram, {12'h3FF, 40'h000ABCDEF1});
    i_dcc_host_model.word(40'h123456789A, 5);
    i_dcc_host_model.close();
    chk(last_ram, {12'h400, 40'h123456789A});
    i_dcc_host_model.open(7'h15, 1'b0, 12'h100);
    i_dcc_host_model.word(40'h01020304, 4);
    i_dcc_host_model.close();
    chk(n_ram, 2);
    i_dcc_host_model.open(CHIP, 1'b0, 12'hA53);
    i_dcc_host_model.word(40'h05, 1);
    i_dcc_host_model.word(40'h07, 1);
    i_dcc_host_model.close();
    rd_reg(12'hA53, 1);
    chk(rd, 16'h0005);
    core_dm_addr = 13'h1000;
    core_dm_wdata = 28'h0000123;
    core_dm_we = 1'b1;
    repeat (2) @(negedge clk);
    chk(dm_addr, 13'h1000);
    core_dm_we = 1'b0;
    // low addresses move by one per frame and wrap at the 0xA00 boundary
    core_dm_addr = 13'h0000;
    align();
    dm_seen = dm_addr;
    align();
    chk(dm_addr, (dm_seen == 13'h09FF) ? 13'h0000 : dm_seen + 13'h0001);
  endtask
  task t_safe();
    n_sl = 0;
    wr(12'hA01, 40'h0312345678, 5);
    wr(12'hA06, 40'h0000, 2);
    align();
    wr(12'hA52, 40'h0213, 2);
    rd_reg(12'hA52, 2);
    chk(rd[4], 1'b1);
    // stays inside one 400-cycle frame counted from the start bit
    repeat (360) @(negedge clk);
    chk(n_sl, 1);
    chk(last_sl, {1'b0, 10'h000, 34'h312345678});
    rd_reg(12'hA52, 2);
    chk(rd, 16'h0203);
    wr(12'hA06, 40'h0005, 2);
    align();
    wr(12'hA52, 40'h0223, 2);
    repeat (380) @(negedge clk);
    chk(n_sl, 2);
    chk(last_sl, {1'b1, 10'h005, 34'h312345678});
  endtask
  // eight input frames per window; last pass moves the transfer to output frames
  task t_sync();
    for (int s = 0; s < 5; s++)
    begin
      wr(12'hA52, (s < 4) ? (40'h0203 | 40'(s << 2)) : 40'h0603, 2);
      align();
      n_end = 0;
      n_lat = 0;
      repeat (3200) @(negedge clk);
      chk(n_end, (s < 4) ? (8 >> s) : 8);
      chk(n_lat, (s < 4) ? (8 >> s) : 16);
    end
    chk(pc, 11'd191);
    // 384 steps stop before the next frame edge, 768 steps are still running there
    wr(12'hA52, 40'h0202, 2);
    @(posedge in_frame_clk);
    repeat (395) @(negedge clk);
    chk(pc, 11'd383);
    wr(12'hA52, 40'h0201, 2);
    @(posedge in_frame_clk);
    repeat (395) @(negedge clk);
    chk(pc > 11'd383, 1'b1);
  endtask
  task t_zero();
    n_zero = 0;
    wr(12'hA52, 40'h0283, 2);
    repeat (6300) @(negedge clk);
    chk(n_zero, 6144);
    rd_reg(12'hA52, 2);
    chk(rd, 16'h0203);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    mult_in = 28'h0;
    in_sample = 24'h0;
    core_dm_addr = 13'h0;
    core_dm_we = 1'b0;
    core_dm_wdata = 28'h0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_gate();
    t_burst();
    t_safe();
    t_sync();
    t_zero();
    stop_test();
  end
  // about twice the expected run
  initial
  begin
    #600000;
    bad_count++;
    stop_test();
  end
endmodule
